// *** pasc_pkg.sv ***
// Notes on behaviour
// - A pin whose analog select bit is set reads back as 0 on every read of its port bit.
// - Analog select never changes what a pin drives; an output pin keeps driving its latch.
// - Analog select low bits 7..0 map to port E pins 2,1,0 and port A pins 5,3,2,1,0.
// - An analog select bit of 1 disables the digital input, 0 enables it.
// - Analog select high bits 4..0 map to port B pins 0,4,1,3,2.
// - Bits 7..5 of analog select high and of slew select are unimplemented and read 0.
// - Reset value of analog select high bits follows the port B analog default config bit.
// - Each port has a slew select choosing standard or 0.1x reduced edge rate.
// - After reset every port uses the reduced edge rate.
// - Slew bits 4..0 select ports E,D,C,B,A; 1 limits the rate, 0 is standard.
// - Port A pin 6 uses the standard rate while it carries the clock output function.
// - On the small package the port E analog bits and port D/E slew bits are absent.
package pasc_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0] ANALOG_SELECT_LOW_OFS = 4'h0;
  localparam logic [3:0] ANALOG_SELECT_HIGH_OFS = 4'h1;
  localparam logic [3:0] SLEW_RATE_SELECT_OFS = 4'h2;
  localparam logic [3:0] PORT_A_READ_OFS = 4'h3;
  localparam logic [3:0] PORT_B_READ_OFS = 4'h4;
  localparam logic [3:0] PORT_E_READ_OFS = 4'h5;

  // ==========================================================
  // Reset values and implemented masks
  localparam logic [7:0] ANALOG_LOW_RESET = 8'hFF;
  localparam logic [7:0] ANALOG_HIGH_MASK = 8'h1F;
  localparam logic [7:0] SLEW_RESET = 8'h1F;
  localparam logic [7:0] SLEW_MASK = 8'h1F;
  localparam logic [7:0] ANALOG_LOW_SMALL_MASK = 8'h1F;
  localparam logic [7:0] SLEW_SMALL_MASK = 8'h07;

  // ==========================================================
  // Field positions
  localparam int ALOW_E2 = 7;
  localparam int ALOW_E1 = 6;
  localparam int ALOW_E0 = 5;
  localparam int ALOW_A5 = 4;
  localparam int ALOW_A3 = 3;
  localparam int ALOW_A2 = 2;
  localparam int ALOW_A1 = 1;
  localparam int ALOW_A0 = 0;
  localparam int AHIGH_B0 = 4;
  localparam int AHIGH_B4 = 3;
  localparam int AHIGH_B1 = 2;
  localparam int AHIGH_B3 = 1;
  localparam int AHIGH_B2 = 0;
  localparam int SLEW_E = 4;
  localparam int SLEW_D = 3;
  localparam int SLEW_C = 2;
  localparam int SLEW_B = 1;
  localparam int SLEW_A = 0;
  localparam int PIN_A6 = 6;

endpackage

// *** pasc_read_gate.sv ***
`timescale 1ns/1ps
// Masks one port's raw pin levels with its per-pin analog disables.
module pasc_read_gate
(
  input wire logic [7:0] pinLevel,
  input wire logic [7:0] analogDisable,
  output logic [7:0] readValue
);

  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_bit
      assign readValue[i] = pinLevel[i] & ~analogDisable[i];
    end
  endgenerate

endmodule

// *** port_analog_and_slew_control.sv ***
`timescale 1ns/1ps
module port_analog_and_slew_control
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic smallPackage,
  input wire logic portb_analog_default_cfg,
  input wire logic clock_output_function,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [7:0] regRdData,
  input wire logic [7:0] portAPins,
  input wire logic [7:0] portBPins,
  input wire logic [7:0] portEPins,
  output logic [7:0] portAReadValue,
  output logic [7:0] portBReadValue,
  output logic [7:0] portEReadValue,
  output logic [4:0] portSlewLimit,
  output logic port_a_pin6SlewLimit
);

  // ==========================================================
  // Storage
  logic [7:0] analogLow_q;
  logic [7:0] analogHigh_q;
  logic [7:0] slew_q;
  logic [7:0] regRdData_q;
  logic cfgLoad_q;

  // ==========================================================
  // Variant masks
  wire [7:0] lowMask = smallPackage ? pasc_pkg::ANALOG_LOW_SMALL_MASK : 8'hFF;
  wire [7:0] slewMask = smallPackage ? pasc_pkg::SLEW_SMALL_MASK : pasc_pkg::SLEW_MASK;
  wire [7:0] analogLowEff = analogLow_q & lowMask;
  wire [7:0] slewEff = slew_q & slewMask;
  wire [7:0] analogHighReset = portb_analog_default_cfg ? pasc_pkg::ANALOG_HIGH_MASK : 8'h00;

  wire wrLow = regWrStrobe && (regAddr == pasc_pkg::ANALOG_SELECT_LOW_OFS);
  wire wrHigh = regWrStrobe && (regAddr == pasc_pkg::ANALOG_SELECT_HIGH_OFS);
  wire wrSlew = regWrStrobe && (regAddr == pasc_pkg::SLEW_RATE_SELECT_OFS);

  // ==========================================================
  // Per-pin analog disables arranged by port bit
  wire [7:0] disA;
  wire [7:0] disB;
  wire [7:0] disE;
  assign disA = {2'h0, analogLowEff[pasc_pkg::ALOW_A5], 1'b0,
                 analogLowEff[pasc_pkg::ALOW_A3], analogLowEff[pasc_pkg::ALOW_A2],
                 analogLowEff[pasc_pkg::ALOW_A1], analogLowEff[pasc_pkg::ALOW_A0]};
  assign disB = {3'h0, analogHigh_q[pasc_pkg::AHIGH_B4], analogHigh_q[pasc_pkg::AHIGH_B3],
                 analogHigh_q[pasc_pkg::AHIGH_B2], analogHigh_q[pasc_pkg::AHIGH_B1],
                 analogHigh_q[pasc_pkg::AHIGH_B0]};
  assign disE = {5'h00, analogLowEff[pasc_pkg::ALOW_E2], analogLowEff[pasc_pkg::ALOW_E1],
                 analogLowEff[pasc_pkg::ALOW_E0]};

  // Gating before the read mux, so read-modify-write sees zero on analog pins
  pasc_read_gate u_gate_a
  (
    .pinLevel(portAPins),
    .analogDisable(disA),
    .readValue(portAReadValue)
  );
  pasc_read_gate u_gate_b
  (
    .pinLevel(portBPins),
    .analogDisable(disB),
    .readValue(portBReadValue)
  );
  pasc_read_gate u_gate_e
  (
    .pinLevel(portEPins),
    .analogDisable(disE),
    .readValue(portEReadValue)
  );

  // No output enable or drive path passes through this block, so outputs are untouched
  assign portSlewLimit = slewEff[4:0];
  assign port_a_pin6SlewLimit = slewEff[pasc_pkg::SLEW_A] & ~clock_output_function;

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      analogLow_q <= pasc_pkg::ANALOG_LOW_RESET;
      slew_q <= pasc_pkg::SLEW_RESET;
      analogHigh_q <= 8'h00;
      cfgLoad_q <= 1'b1;
    end
    else
    begin
      // Config bit is caught after release since async reset takes constants only
      cfgLoad_q <= 1'b0;
      if (cfgLoad_q)
        analogHigh_q <= analogHighReset;
      else if (wrHigh)
        analogHigh_q <= regWrData & pasc_pkg::ANALOG_HIGH_MASK;
      if (wrLow)
        analogLow_q <= regWrData;
      if (wrSlew)
        slew_q <= regWrData & pasc_pkg::SLEW_MASK;
    end
  end

  // ==========================================================
  // Read mux, data one cycle after the strobe
  logic [7:0] rdMux;
  always_comb
  begin
    unique case (regAddr)
      pasc_pkg::ANALOG_SELECT_LOW_OFS: rdMux = analogLowEff;
      pasc_pkg::ANALOG_SELECT_HIGH_OFS: rdMux = analogHigh_q;
      pasc_pkg::SLEW_RATE_SELECT_OFS: rdMux = slewEff;
      pasc_pkg::PORT_A_READ_OFS: rdMux = portAReadValue;
      pasc_pkg::PORT_B_READ_OFS: rdMux = portBReadValue;
      pasc_pkg::PORT_E_READ_OFS: rdMux = portEReadValue;
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      regRdData_q <= 8'h00;
    else
      regRdData_q <= regRdStrobe ? rdMux : 8'h00;
  end

  assign regRdData = regRdData_q;

endmodule

// *** pasc_assertions.sv ***
`timescale 1ns/1ps
module pasc_assertions
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic smallPackage,
  input wire logic clock_output_function,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  input wire logic [7:0] regRdData,
  input wire logic [7:0] portAPins,
  input wire logic [7:0] portAReadValue,
  input wire logic [4:0] portSlewLimit,
  input wire logic port_a_pin6SlewLimit
);
  // ==========
  // Checks
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);
  pin6_slew_a: assert property
    (port_a_pin6SlewLimit == (portSlewLimit[0] & ~clock_output_function)) else $error("pin6 slew");
  small_slew_a: assert property
    (smallPackage |-> portSlewLimit[4:3] == 2'b00) else $error("small slew");
  reset_slew_a: assert property
    ($past(rst) && !smallPackage |-> portSlewLimit == 5'h1F) else $error("reset slew");
  slew_write_a: assert property
    (regWrStrobe && regAddr == 4'h2 && !smallPackage |=> portSlewLimit == 5'($past(regWrData)))
    else $error("slew write");
  upper_zero_a: assert property
    (regRdStrobe && regAddr inside {4'h1, 4'h2} |=> regRdData[7:5] == 3'b000) else $error("upper");
  port_read_a: assert property
    (regRdStrobe && regAddr == 4'h3 |=> regRdData == $past(portAReadValue)) else $error("port read");
  gate_zero_a: assert property
    ((portAReadValue & ~portAPins) == 8'h00 && portAReadValue[7:6] == portAPins[7:6]
     && portAReadValue[4] == portAPins[4]) else $error("gate zero");
  analog_set_a: assert property
    (regWrStrobe && regAddr == 4'h0 && regWrData[0] |=> !portAReadValue[0]) else $error("analog set");
endmodule
bind port_analog_and_slew_control pasc_assertions pasc_assertions_inst (.*);

// *** port_analog_and_slew_control_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin nMismatch++; $display("unexpected %s exp %h got %h", n, e, g); end end
module port_analog_and_slew_control_tb_top;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} pasc_row_t;
  // Address, written value, value read back
  pasc_row_t rows[5] = '{'{4'h0, 8'hA5, 8'hA5}, '{4'h1, 8'hFF, 8'h1F}, '{4'h2, 8'hFF, 8'h1F},
    '{4'h2, 8'h0A, 8'h0A}, '{4'hF, 8'h5A, 8'h00}};
  logic core_clk = 0, rst, smallPackage, portb_analog_default_cfg, clock_output_function;
  logic regWrStrobe, regRdStrobe, port_a_pin6SlewLimit;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, portAPins, portBPins, portEPins;
  logic [7:0] portAReadValue, portBReadValue, portEReadValue;
  logic [4:0] portSlewLimit;
  int nMismatch = 0, testsRun = 0, cycles = 0;
  port_analog_and_slew_control port_analog_and_slew_control_inst (.*);
  always #5 core_clk = ~core_clk;
  // ==========
  // Bus tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {regAddr, regWrData, regWrStrobe} <= {a, d, 1'b1};
    @(posedge core_clk);
    regWrStrobe <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    {regAddr, regRdStrobe} <= {a, 1'b1};
    @(posedge core_clk);
    regRdStrobe <= 1'b0;
    #1;
    `CHK("read data", e, regRdData)
  endtask
  // Mid-run resets reuse this, so the config level is set while reset holds
  task automatic doReset(input logic cfg);
    if (rst === 1'b0)
      @(posedge core_clk);
    {rst, portb_analog_default_cfg} <= {1'b1, cfg};
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Whole run is under 60 cycles
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      nMismatch++;
      conclude();
    end
  end
  initial
  begin
    {regAddr, regWrData, regWrStrobe, regRdStrobe} <= '0;
    {smallPackage, clock_output_function} <= 2'b00;
    {portAPins, portBPins, portEPins} <= {3{8'hFF}};
    doReset(1'b1);
    rd(4'h0, 8'hFF);
    rd(4'h1, 8'h1F);
    rd(4'h2, 8'h1F);
    $display("reset values done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    $display("register table done");
    wr(4'h0, 8'hEF);
    `CHK("port A", 8'hF0, portAReadValue)
    `CHK("port E", 3'b000, portEReadValue[2:0])
    rd(4'h3, 8'hF0);
    wr(4'h1, 8'h11);
    `CHK("port B", 8'hFA, portBReadValue)
    rd(4'h4, 8'hFA);
    $display("gating done");
    @(posedge core_clk);
    smallPackage <= 1'b1;
    wr(4'h2, 8'h1F);
    `CHK("small E", 3'b111, portEReadValue[2:0])
    `CHK("small slew", 5'h07, portSlewLimit)
    rd(4'h2, 8'h07);
    `CHK("pin6 limited", 1'b1, port_a_pin6SlewLimit)
    @(posedge core_clk);
    {smallPackage, clock_output_function} <= 2'b01;
    #1;
    `CHK("pin6 slew", 1'b0, port_a_pin6SlewLimit)
    $display("package and clock out done");
    doReset(1'b0);
    rd(4'h1, 8'h00);
    $display("second reset done");
    conclude();
  end
endmodule
